// *** hw/etcu_pkg.sv ***
// Constants and types of the eight bit timer counter unit
package etcu_pkg;

    localparam int AW = 12;
    localparam int DW = 32;
    localparam int CW = 8;
    localparam int PW = 10;

    // Register byte offsets
    localparam logic [AW-1:0] OFS_CTRL_A = 12'h000;
    localparam logic [AW-1:0] OFS_CTRL_B = 12'h004;
    localparam logic [AW-1:0] OFS_COUNT = 12'h008;
    localparam logic [AW-1:0] OFS_CMP_A = 12'h00c;
    localparam logic [AW-1:0] OFS_CMP_B = 12'h010;
    localparam logic [AW-1:0] OFS_MASK = 12'h014;
    localparam logic [AW-1:0] OFS_FLAG = 12'h018;
    localparam logic [AW-1:0] OFS_PWR = 12'h01c;
    localparam logic [AW-1:0] OFS_LAST = 12'h01c;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // Field positions
    localparam int CA_WM_LSB = 0;
    localparam int CA_COMB_LSB = 4;
    localparam int CA_COMA_LSB = 6;
    localparam int CB_CS_LSB = 2'h0;
    localparam int CB_WM2_BIT = 3;
    localparam int FL_OVF = 0;
    localparam int FL_CMPA = 1;
    localparam int FL_CMPB = 2;
    localparam int PWR_BIT = 0;

    // Counter landmarks
    localparam logic [CW-1:0] CNT_BOTTOM = 8'h00;
    localparam logic [CW-1:0] CNT_MAX = 8'hff;
    localparam logic [CW-1:0] CNT_ONE = 8'h01;

    // Clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // Prescaler taps, all ones marks the divided tick
    localparam logic [PW-1:0] PRESC_ONE = 10'h001;
    localparam logic [PW-1:0] TAP_DIV8 = 10'h007;
    localparam logic [PW-1:0] TAP_DIV64 = 10'h03f;
    localparam logic [PW-1:0] TAP_DIV256 = 10'h0ff;
    localparam logic [PW-1:0] TAP_DIV1024 = 10'h3ff;

    // Wave mode codes
    localparam logic [2:0] WM_NORMAL = 3'h0;
    localparam logic [2:0] WM_PC_MAX = 3'h1;
    localparam logic [2:0] WM_CTC = 3'h2;
    localparam logic [2:0] WM_FAST_MAX = 3'h3;
    localparam logic [2:0] WM_PC_CMP = 3'h5;
    localparam logic [2:0] WM_FAST_CMP = 3'h7;

    // Compare output actions
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    typedef enum logic [2:0] {
        ETCU_K_NORM = 3'b001,
        ETCU_K_FAST = 3'b010,
        ETCU_K_PHASE = 3'b100
    } etcu_kind_e;

    typedef struct packed {
        logic [AW-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [DW-1:0] pwdata;
    } etcu_apb_req_s;

    typedef struct packed {
        logic [DW-1:0] prdata;
        logic pready;
        logic pslverr;
    } etcu_apb_rsp_s;

    typedef struct packed {
        logic [CW-1:0] ctrl_a;
        logic [CW-1:0] ctrl_b;
        logic [CW-1:0] count;
        logic [CW-1:0] buf_a;
        logic [CW-1:0] buf_b;
        logic [CW-1:0] act_a;
        logic [CW-1:0] act_b;
        logic [2:0] mask;
        logic [2:0] flag;
        logic pwr_off;
        logic dir_down;
        logic blk;
        logic [2:0] pin_s;
        logic [PW-1:0] presc;
        logic out_a;
        logic out_b;
        logic [DW-1:0] rdata;
        logic slverr;
    } etcu_state_s;

endpackage : etcu_pkg

// *** hw/etcu_top.sv ***
// Eight bit timer counter unit with APB register access
//
// Notes on behaviour
// RL1: Each tick clears, increments or decrements the counter as the mode says.
// RL2: Clock select zero gives no ticks; the timer stands still.
// RL3: Software reads and writes the counter at any time.
// RL4: A counter write wins over a same-cycle clear or count.
// RL5: A three bit clock select field in control B picks the source.
// RL6: Source is the prescaler or the external pin, with a chosen edge.
// RL7: Wave mode has two bits in control A and one in control B.
// RL8: Counter zero is bottom, flagged by a bottom indication.
// RL9: All ones is the counter maximum.
// RL10: Top is the maximum or compare A, chosen by mode.
// RL11: Top and bottom indications go to the waveform logic.
// RL12: Both compare values are checked always; equality sets a compare flag.
// RL13: Overflow and both compare flags sit in one register, each maskable.
// RL14: Overflow flag sets on a mode dependent condition and may interrupt.
// RL15: Compare values are double buffered: written buffer apart from active. The code buffers only in PWM modes; other modes copy it every cycle.
// RL16: Counter and compare values are eight bits wide.
// RL17: Power reduction bit at zero enables the timer.
// RL18: Compare results drive PWM or frequency output on two pins.
// RL19: A compare flag sets at the tick that follows the match.
// RL20: A flag clears on interrupt acknowledge or when written with one.
// RL21: A counter write blocks compare matches in the next tick.
// RL22: Normal mode counts up, wraps at all ones, sets overflow at zero.
// RL23: Reset clears counter, compares, flags and masks; no clock selected.
// RL24: An interrupt request stands while flag and mask are both set.
`timescale 1ns/1ps
`default_nettype none

module etcu_top (
    // Clock, reset and freeze
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Register bus
    input wire etcu_pkg::etcu_apb_req_s apb_req,
    output var etcu_pkg::etcu_apb_rsp_s apb_rsp,
    // External count pin
    input wire logic external_tick_pin,
    // Interrupt requests and acknowledges
    input wire logic [2:0] irq_ack,
    output logic [2:0] irq_req,
    // Waveform pins and counter landmarks
    output logic compare_output_a,
    output logic compare_output_b,
    output logic at_top,
    output logic at_bottom
);
    import etcu_pkg::*;

    etcu_state_s st_q;
    etcu_state_s st_d;
    logic [2:0] cs;
    logic [2:0] wm;
    etcu_kind_e kind;
    logic [CW-1:0] top;
    logic tick;
    logic ext_rise;
    logic ext_fall;
    logic setup;
    logic wr;
    logic hit;
    logic [AW-1:0] adr;
    logic cnt_wr;
    logic dn_nx;
    logic wrap;
    logic [2:0] fset;
    logic [2:0] fclr;

    function automatic etcu_kind_e mode_kind(input logic [2:0] m);
        etcu_kind_e k;
        k = ETCU_K_NORM;
        case (m)
            WM_FAST_MAX, WM_FAST_CMP: k = ETCU_K_FAST;
            WM_PC_MAX, WM_PC_CMP: k = ETCU_K_PHASE;
            default: k = ETCU_K_NORM;
        endcase
        return k;
    endfunction : mode_kind

    function automatic logic pick_tick(
        input logic [2:0] sel,
        input logic [PW-1:0] p,
        input logic rise,
        input logic fall
    );
        logic t;
        t = 1'b0;
        case (sel)
            CS_DIV1: t = 1'b1;
            CS_DIV8: t = (p & TAP_DIV8) == TAP_DIV8;
            CS_DIV64: t = (p & TAP_DIV64) == TAP_DIV64;
            CS_DIV256: t = (p & TAP_DIV256) == TAP_DIV256;
            CS_DIV1024: t = (p & TAP_DIV1024) == TAP_DIV1024;
            CS_EXT_FALL: t = fall;
            CS_EXT_RISE: t = rise;
            default: t = 1'b0;
        endcase
        return t;
    endfunction : pick_tick

    // Next level of a compare output pin
    function automatic logic wave_nx(
        input logic o,
        input logic [1:0] c,
        input logic m,
        input logic wr_top,
        input etcu_kind_e k,
        input logic dn
    );
        logic v;
        v = o;
        if (c != COM_OFF) begin
            case (k)
                ETCU_K_FAST: begin
                    if (m) begin
                        v = (c == COM_SET);
                    end else if (wr_top) begin
                        v = (c == COM_CLEAR);
                    end
                end
                ETCU_K_PHASE: begin
                    if (m) begin
                        v = (c == COM_SET) ^ dn;
                    end
                end
                default: begin
                    if (m) begin
                        v = (c == COM_TOGGLE) ? ~o : (c == COM_SET);
                    end
                end
            endcase
        end
        return v;
    endfunction : wave_nx

    function automatic logic [DW-1:0] rd_word(
        input logic [AW-1:0] a,
        input etcu_state_s s
    );
        logic [CW-1:0] b;
        b = '0;
        case (a)
            OFS_CTRL_A: b = s.ctrl_a;
            OFS_CTRL_B: b = s.ctrl_b;
            OFS_COUNT: b = s.count; // [RL3]
            OFS_CMP_A: b = s.buf_a;
            OFS_CMP_B: b = s.buf_b;
            OFS_MASK: b = {5'h00, s.mask};
            OFS_FLAG: b = {5'h00, s.flag}; // [RL13]
            OFS_PWR: b = {7'h00, s.pwr_off};
            default: b = '0;
        endcase
        return {{(DW-CW){1'b0}}, b};
    endfunction : rd_word

    assign cs = st_q.ctrl_b[CB_CS_LSB +: 3]; // [RL5]
    assign wm = {st_q.ctrl_b[CB_WM2_BIT],
                 st_q.ctrl_a[CA_WM_LSB +: 2]}; // [RL7]
    assign kind = mode_kind(wm);
    // Top follows compare A only in the modes that reload from it
    assign top = (wm == WM_CTC || wm == WM_PC_CMP || wm == WM_FAST_CMP)
        ? st_q.act_a : CNT_MAX; // [RL9] [RL10]

    // Edge detect reads only the second and third pin stages
    assign ext_rise = st_q.pin_s[1] & ~st_q.pin_s[2];
    assign ext_fall = ~st_q.pin_s[1] & st_q.pin_s[2];
    assign tick = ~st_q.pwr_off
        & pick_tick(cs, st_q.presc, ext_rise, ext_fall); // [RL2] [RL6] [RL17]

    assign adr = apb_req.paddr;
    assign setup = apb_req.psel & ~apb_req.penable;
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign hit = (adr <= OFS_LAST) && (adr[1:0] == WORD_ALIGN);
    assign cnt_wr = wr & (adr == OFS_COUNT);

    // Phase correct turns at top and at bottom
    assign dn_nx = (kind == ETCU_K_PHASE)
        && ((st_q.count == top)
            || (st_q.dir_down && st_q.count != CNT_BOTTOM));
    assign wrap = tick & (st_q.count == top);

    always_comb begin
        fset = '0;
        case (kind)
            ETCU_K_PHASE: fset[FL_OVF] = tick
                & (st_q.count == CNT_BOTTOM);
            ETCU_K_FAST: fset[FL_OVF] = wrap;
            default: fset[FL_OVF] = tick
                & (st_q.count == CNT_MAX); // [RL14] [RL22]
        endcase
        // A counter write discards the count step, and its overflow too
        fset[FL_OVF] = fset[FL_OVF] & ~cnt_wr; // [RL4]
        // Flag lands on the tick after the counter reached the value
        fset[FL_CMPA] = tick & ~st_q.blk
            & (st_q.count == st_q.act_a); // [RL12] [RL19] [RL21]
        fset[FL_CMPB] = tick & ~st_q.blk
            & (st_q.count == st_q.act_b); // [RL12] [RL19] [RL21]
    end

    assign fclr = irq_ack
        | ((wr && adr == OFS_FLAG) ? apb_req.pwdata[2:0] : 3'h0); // [RL20]

    always_comb begin
        st_d = st_q;
        st_d.pin_s = {st_q.pin_s[1:0], external_tick_pin};
        // Prescaler held at zero while stopped so division restarts clean
        if (cs == CS_STOP || st_q.pwr_off) begin
            st_d.presc = '0;
        end else begin
            st_d.presc = st_q.presc + PRESC_ONE;
        end

        if (tick) begin
            case (kind)
                ETCU_K_PHASE: st_d.count = dn_nx
                    ? st_q.count - CNT_ONE
                    : st_q.count + CNT_ONE; // [RL1]
                default: st_d.count = (st_q.count == top)
                    ? CNT_BOTTOM
                    : st_q.count + CNT_ONE; // [RL1] [RL22]
            endcase
            st_d.dir_down = dn_nx;
            st_d.blk = 1'b0;
        end

        // Double buffering only in PWM modes, updated at top
        if (kind == ETCU_K_NORM || wrap) begin
            st_d.act_a = st_q.buf_a; // [RL15]
            st_d.act_b = st_q.buf_b; // [RL15]
        end

        // A flag event in the clearing cycle survives
        st_d.flag = (st_q.flag & ~fclr) | fset; // [RL13] [RL20]

        st_d.out_a = wave_nx(st_q.out_a,
            st_q.ctrl_a[CA_COMA_LSB +: 2], fset[FL_CMPA], wrap,
            kind, st_q.dir_down); // [RL18]
        st_d.out_b = wave_nx(st_q.out_b,
            st_q.ctrl_a[CA_COMB_LSB +: 2], fset[FL_CMPB], wrap,
            kind, st_q.dir_down); // [RL18]

        // Read data captured in the setup cycle; zero wait access
        if (setup) begin
            st_d.rdata = apb_req.pwrite ? '0 : rd_word(adr, st_q);
            st_d.slverr = ~hit;
        end

        if (wr) begin
            case (adr)
                OFS_CTRL_A: st_d.ctrl_a = apb_req.pwdata[CW-1:0];
                OFS_CTRL_B: st_d.ctrl_b = apb_req.pwdata[CW-1:0];
                OFS_COUNT: begin
                    st_d.count = apb_req.pwdata[CW-1:0]; // [RL3] [RL4]
                    st_d.blk = 1'b1; // [RL21]
                end
                OFS_CMP_A: st_d.buf_a = apb_req.pwdata[CW-1:0];
                OFS_CMP_B: st_d.buf_b = apb_req.pwdata[CW-1:0];
                OFS_MASK: st_d.mask = apb_req.pwdata[2:0]; // [RL13]
                OFS_PWR: st_d.pwr_off = apb_req.pwdata[PWR_BIT];
                default: st_d.ctrl_a = st_q.ctrl_a;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0; // [RL23]
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign apb_rsp.prdata = st_q.rdata;
    // A frozen block stalls the bus so that no write lands half way
    assign apb_rsp.pready = clk_en;
    assign apb_rsp.pslverr = st_q.slverr;
    assign irq_req = st_q.flag & st_q.mask; // [RL24]
    assign compare_output_a = st_q.out_a;
    assign compare_output_b = st_q.out_b;
    assign at_top = (st_q.count == top); // [RL11]
    assign at_bottom = (st_q.count == CNT_BOTTOM); // [RL8] [RL11] [RL16]

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_STOPPED: assert property ( // [RL2]
        clk_en && cs == CS_STOP && !cnt_wr
        |=> st_q.count == $past(st_q.count))
        else $error("counter moved with no clock selected");

    AST_PWR_OFF: assert property ( // [RL17]
        clk_en && st_q.pwr_off && !cnt_wr
        |=> st_q.count == $past(st_q.count))
        else $error("counter moved while powered down");

    AST_INC_NORMAL: assert property ( // [RL1]
        clk_en && tick && wm == WM_NORMAL && !cnt_wr
        && st_q.count != CNT_MAX
        |=> st_q.count == $past(st_q.count) + CNT_ONE)
        else $error("normal mode did not increment");

    AST_WRITE_WINS: assert property ( // [RL4]
        clk_en && cnt_wr
        |=> st_q.count == $past(apb_req.pwdata[CW-1:0]))
        else $error("counter write lost");

    AST_OVF_NORMAL: assert property ( // [RL22]
        clk_en && tick && wm == WM_NORMAL && !cnt_wr
        && st_q.count == CNT_MAX
        |=> st_q.count == CNT_BOTTOM && st_q.flag[FL_OVF])
        else $error("normal wrap without overflow");

    AST_CMP_A_FLAG: assert property ( // [RL19]
        clk_en && tick && !st_q.blk && !cnt_wr
        && st_q.count == st_q.act_a
        |=> st_q.flag[FL_CMPA])
        else $error("compare A flag not set");

    AST_BLOCK: assert property ( // [RL21]
        (clk_en && cnt_wr) ##1 (clk_en && tick && !cnt_wr
        && !st_q.flag[FL_CMPA] && !st_q.flag[FL_CMPB])
        |=> !st_q.flag[FL_CMPA] && !st_q.flag[FL_CMPB])
        else $error("match not blocked after counter write");

    AST_W1C: assert property ( // [RL20]
        clk_en && wr && adr == OFS_FLAG
        && apb_req.pwdata[FL_CMPB] && !fset[FL_CMPB]
        |=> !st_q.flag[FL_CMPB])
        else $error("flag not cleared by write of one");

    AST_IRQ: assert property ( // [RL24]
        clk_en && wr && adr == OFS_FLAG && apb_req.pwdata[FL_OVF]
        && !fset[FL_OVF]
        |=> !irq_req[FL_OVF])
        else $error("overflow request stayed after its flag was cleared");

    AST_DBUF: assert property ( // [RL15]
        clk_en && kind != ETCU_K_NORM && !wrap
        |=> $stable(st_q.act_a))
        else $error("active compare moved outside top");

    AST_BOTTOM: assert property ( // [RL8]
        clk_en && tick && kind == ETCU_K_NORM && !cnt_wr
        && st_q.count == top |=> at_bottom)
        else $error("bottom indication missing after wrap");

    AST_CTC_CLEAR: assert property ( // [RL10]
        clk_en && tick && wm == WM_CTC && !cnt_wr
        && st_q.count == st_q.act_a |=> st_q.count == CNT_BOTTOM)
        else $error("clear on compare A missed");

    AST_PHASE_TURN: assert property ( // [RL1]
        clk_en && tick && kind == ETCU_K_PHASE && !cnt_wr
        && st_q.count == top
        |=> st_q.dir_down && st_q.count == $past(st_q.count) - CNT_ONE)
        else $error("phase correct count did not turn at top");

    AST_SET_WINS: assert property ( // [RL14]
        clk_en && fset[FL_OVF] |=> st_q.flag[FL_OVF])
        else $error("overflow event lost to a clear");

    COV_OVF: cover property (clk_en && fset[FL_OVF]);
    COV_CMP_A: cover property (clk_en && fset[FL_CMPA]);
    COV_DOWN: cover property (clk_en && tick && st_q.dir_down);
    COV_BLOCK: cover property (clk_en && cnt_wr ##1 tick);

endmodule : etcu_top

`default_nettype wire

// *** verif/etcu_top_test.sv ***
// Self-checking bench for the eight bit timer counter unit
`timescale 1ns/1ps
`default_nettype none

module etcu_top_test;
    import etcu_pkg::*;

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    etcu_apb_req_s apb_req = '0;
    etcu_apb_rsp_s apb_rsp;
    logic external_tick_pin = 1'b0;
    logic [2:0] irq_ack = 3'h0;
    logic [2:0] irq_req;
    logic compare_output_a;
    logic compare_output_b;
    logic at_top;
    logic at_bottom;
    logic [31:0] rdat;
    logic err;
    logic seen_top;
    int error_cnt = 0;
    int total_checks = 0;

    always #25 ref_clk = ~ref_clk;

    etcu_top dut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .external_tick_pin(external_tick_pin),
        .irq_ack(irq_ack),
        .irq_req(irq_req),
        .compare_output_a(compare_output_a),
        .compare_output_b(compare_output_b),
        .at_top(at_top),
        .at_bottom(at_bottom)
    );

    task final_report;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; starts and ends on a rising edge
    task apb(input logic [AW-1:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        apb_req.paddr <= a;
        apb_req.pwrite <= w;
        apb_req.pwdata <= d;
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            final_report();
        end
        rdat = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    task wr(input logic [AW-1:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr

    task rdc(input logic [AW-1:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0000_0000);
        check(rdat, exp);
        check({31'h0, err}, 32'h0000_0000);
    endtask : rdc

    // Count value after running the timer from a written start value
    task run_from(input logic [7:0] start, input logic [7:0] cs, input int cyc);
        wr(OFS_COUNT, {24'h0, start});
        wr(OFS_CTRL_B, {24'h0, cs});
        repeat (cyc) @(posedge ref_clk);
        wr(OFS_CTRL_B, 32'h0000_0000);
        apb(OFS_COUNT, 1'b0, 32'h0000_0000);
    endtask : run_from

    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i <= 7; i++) begin
            rdc(12'(i * 4), 32'h0000_0000);
        end
        check({31'h0, at_bottom}, 32'h1);
        check({29'h0, irq_req}, 32'h0);
        apb(12'h020, 1'b0, 32'h0000_0000);
        check({31'h0, err}, 32'h1);
        apb(12'h002, 1'b0, 32'h0000_0000);
        check({31'h0, err}, 32'h1);
        // Stopped timer keeps a written value
        wr(OFS_COUNT, 32'h0000_0010);
        repeat (20) @(posedge ref_clk);
        rdc(OFS_COUNT, 32'h0000_0010);
        // Wrap through all ones in normal mode
        wr(OFS_MASK, 32'h0000_0001);
        rdc(OFS_MASK, 32'h0000_0001);
        run_from(8'hfe, 8'h01, 0);
        check(rdat, 32'h0000_0001);
        rdc(OFS_FLAG, 32'h0000_0007);
        check({29'h0, irq_req}, 32'h1);
        wr(OFS_FLAG, 32'h0000_0001);
        rdc(OFS_FLAG, 32'h0000_0006);
        check({29'h0, irq_req}, 32'h0);
        wr(OFS_MASK, 32'h0000_0006);
        // Let the mask edge settle before looking at the request
        @(posedge ref_clk);
        check({29'h0, irq_req}, 32'h6);
        irq_ack <= 3'h2;
        @(posedge ref_clk);
        irq_ack <= 3'h0;
        rdc(OFS_FLAG, 32'h0000_0004);
        check({29'h0, irq_req}, 32'h4);
        wr(OFS_FLAG, 32'h0000_0007);
        rdc(OFS_FLAG, 32'h0000_0000);
        // A counter write masks the match of the next tick only
        wr(OFS_CMP_A, 32'h0000_0090);
        wr(OFS_CMP_B, 32'h0000_0030);
        rdc(OFS_CMP_B, 32'h0000_0030);
        run_from(8'h30, 8'h01, 0);
        check(rdat, 32'h0000_0033);
        rdc(OFS_FLAG, 32'h0000_0000);
        wr(OFS_CMP_B, 32'h0000_0035);
        wr(OFS_CTRL_B, 32'h0000_0001);
        wr(OFS_CTRL_B, 32'h0000_0000);
        rdc(OFS_FLAG, 32'h0000_0004);
        check({29'h0, irq_req}, 32'h4);
        wr(OFS_FLAG, 32'h0000_0007);
        // Counter write while running wins over the tick
        wr(OFS_CTRL_B, 32'h0000_0001);
        wr(OFS_COUNT, 32'h0000_0040);
        wr(OFS_CTRL_B, 32'h0000_0000);
        rdc(OFS_COUNT, 32'h0000_0043);
        // External pin, rising then falling edges
        wr(OFS_COUNT, 32'h0000_0000);
        for (int e = 0; e < 2; e++) begin
            wr(OFS_CTRL_B, e == 0 ? 32'h0000_0007 : 32'h0000_0006);
            for (int i = 0; i < 3; i++) begin
                @(posedge ref_clk);
                external_tick_pin <= 1'b1;
                repeat (6) @(posedge ref_clk);
                external_tick_pin <= 1'b0;
                repeat (6) @(posedge ref_clk);
            end
            wr(OFS_CTRL_B, 32'h0000_0000);
            rdc(OFS_COUNT, e == 0 ? 32'h3 : 32'h6);
        end
        // Power reduction bit set holds the timer
        wr(OFS_PWR, 32'h0000_0001);
        rdc(OFS_PWR, 32'h0000_0001);
        run_from(8'h00, 8'h01, 10);
        check(rdat, 32'h0000_0000);
        wr(OFS_PWR, 32'h0000_0000);
        // Divide by eight: 83 enabled cycles give ten ticks
        run_from(8'h00, 8'h02, 80);
        check(rdat, 32'h0000_000a);
        // Clear on compare A with output A toggling on each match
        wr(OFS_CTRL_A, 32'h0000_0042);
        wr(OFS_CMP_A, 32'h0000_0010);
        wr(OFS_COUNT, 32'h0000_0000);
        wr(OFS_CTRL_B, 32'h0000_0001);
        seen_top = 1'b0;
        repeat (60) begin
            @(posedge ref_clk);
            seen_top = seen_top | (at_top === 1'b1);
        end
        wr(OFS_CTRL_B, 32'h0000_0000);
        apb(OFS_COUNT, 1'b0, 32'h0000_0000);
        // 63 ticks over a period of 17 leave the count at 12
        check(rdat, 32'h0000_000c);
        check({31'h0, seen_top}, 32'h1);
        rdc(OFS_FLAG, 32'h0000_0002);
        check({30'h0, compare_output_b, compare_output_a}, 32'h1);
        // Phase correct: 15 ticks up to all ones, then 18 down
        wr(OFS_CTRL_A, 32'h0000_0001);
        run_from(8'hf0, 8'h01, 30);
        check(rdat, 32'h0000_00ed);
        // Enable low freezes the counter; three enabled ticks remain
        wr(OFS_CTRL_A, 32'h0000_0000);
        wr(OFS_COUNT, 32'h0000_0020);
        wr(OFS_CTRL_B, 32'h0000_0001);
        clk_en <= 1'b0;
        repeat (10) @(posedge ref_clk);
        clk_en <= 1'b1;
        wr(OFS_CTRL_B, 32'h0000_0000);
        rdc(OFS_COUNT, 32'h0000_0023);
        final_report();
    end
endmodule : etcu_top_test

`default_nettype wire
